// ==== src/dcf_pkg.sv ====
package dcf_pkg;
   // Register byte offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_PTRS = 4'h8;

   // Control field positions
   localparam int CTRL_CODE_LSB = 0;
   localparam int CTRL_VAR_LSB = 6;
   localparam int CTRL_CASC_BIT = 8;

   // Status and pointer field positions
   localparam int ST_EMPTY_BIT = 0;
   localparam int ST_AE_BIT = 1;
   localparam int ST_HF_BIT = 2;
   localparam int ST_AF_BIT = 3;
   localparam int ST_FULL_BIT = 4;
   localparam int ST_EFN_BIT = 5;
   localparam int ST_PAFEN_BIT = 6;
   localparam int ST_HFN_BIT = 7;
   localparam int ST_COUNT_LSB = 16;
   localparam int PTRS_RD_LSB = 16;

   // Reset values
   localparam logic [5:0] CODE_RST = 6'h01;
   localparam logic [1:0] VAR_RST = 2'h2;
   localparam logic CASC_RST = 1'b0;

   // Depth variants
   localparam int PTR_W = 13;
   localparam logic [1:0] VAR_512 = 2'h0;
   localparam logic [1:0] VAR_2K = 2'h1;
   localparam logic [PTR_W-1:0] DEPTH_512 = 13'h0200;
   localparam logic [PTR_W-1:0] DEPTH_2K = 13'h0800;
   localparam logic [PTR_W-1:0] DEPTH_4K = 13'h1000;
   localparam logic [5:0] CODE_MAX_512 = 6'h0f;

   // Timing: opposite-side operations older than this are always counted
   localparam int CLK_NS = 25;
   localparam int SKEW_INCLUDE_NS = 50;
   localparam int SKEW_CYC = (SKEW_INCLUDE_NS + CLK_NS - 1) / CLK_NS;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } dcf_wr_st_t;
endpackage : dcf_pkg

// ==== src/dcf_flags.sv ====
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dcf_flags (
   // System
   input wire logic core_clk,
   input wire logic rst_b,
   // Write port pins
   input wire logic write_clock,
   input wire logic write_enable_n,
   output logic wordStored,
   // Read port pins
   input wire logic read_clock,
   input wire logic read_enable_n,
   output logic wordDelivered,
   // Status pins
   output logic empty_full_flag_n,
   output logic near_boundary_flag_n,
   output logic half_level_flag_n,
   // AXI4-Lite slave
   input wire logic awvalid,
   output logic awready,
   input wire logic [3:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [3:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   localparam int SK = dcf_pkg::SKEW_CYC;
   localparam int PW = dcf_pkg::PTR_W;

   typedef struct packed {
      logic wclkS1;
      logic wclkS2;
      logic wclkS3;
      logic wenS1;
      logic wenS2;
      logic rclkS1;
      logic rclkS2;
      logic rclkS3;
      logic renS1;
      logic renS2;
      logic [PW-1:0] wrPtr;
      logic [PW-1:0] rdPtr;
      logic [SK-1:0][PW-1:0] rdCopy;
      logic [SK-1:0][PW-1:0] wrCopy;
      logic emptyR;
      logic aeR;
      logic fullW;
      logic afW;
      logic hfW;
      logic efN;
      logic pafeN;
      logic hfN;
      logic storedP;
      logic deliveredP;
      logic [5:0] code;
      logic [1:0] variant;
      logic cascade;
      dcf_pkg::dcf_wr_st_t wrSt;
      logic awHeld;
      logic wHeld;
      logic [3:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } dcf_state_t;

   dcf_state_t s_r;
   dcf_state_t s_nxt;
   logic wrEdge;
   logic rdEdge;
   logic [PW-1:0] wrCnt;
   logic [PW-1:0] rdCnt;
   logic [PW-1:0] depth;
   logic [PW-1:0] thr;

   function automatic logic [PW-1:0] depthOf(input logic [1:0] v);
      case (v)
         dcf_pkg::VAR_512: depthOf = dcf_pkg::DEPTH_512;
         dcf_pkg::VAR_2K: depthOf = dcf_pkg::DEPTH_2K;
         default: depthOf = dcf_pkg::DEPTH_4K;
      endcase
   endfunction : depthOf

   function automatic logic [5:0] limitCode(input logic [5:0] c, input logic [1:0] v);
      if (v == dcf_pkg::VAR_512 && c > dcf_pkg::CODE_MAX_512) begin
         limitCode = dcf_pkg::CODE_MAX_512;
      end else begin
         limitCode = c;
      end
   endfunction : limitCode

   assign wrEdge = s_r.wclkS2 & ~s_r.wclkS3;
   assign rdEdge = s_r.rclkS2 & ~s_r.rclkS3;
   assign depth = depthOf(s_r.variant);
   assign thr = {3'h0, s_r.code, 4'h0};

   always_comb begin
      s_nxt = s_r;
      // Link pins are foreign to core_clk, so two flops before use
      s_nxt.wclkS1 = write_clock;
      s_nxt.wclkS2 = s_r.wclkS1;
      s_nxt.wclkS3 = s_r.wclkS2;
      s_nxt.wenS1 = write_enable_n;
      s_nxt.wenS2 = s_r.wenS1;
      s_nxt.rclkS1 = read_clock;
      s_nxt.rclkS2 = s_r.rclkS1;
      s_nxt.rclkS3 = s_r.rclkS2;
      s_nxt.renS1 = read_enable_n;
      s_nxt.renS2 = s_r.renS1;
      s_nxt.storedP = 1'b0;
      s_nxt.deliveredP = 1'b0;
      // Delayed copies model the include skew between the two sides
      s_nxt.rdCopy = {s_r.rdCopy[SK-2:0], s_r.rdPtr};
      s_nxt.wrCopy = {s_r.wrCopy[SK-2:0], s_r.wrPtr};

      // Write side: a shown-full edge is latent, it only refreshes flags
      if (wrEdge && !s_r.fullW && !s_r.wenS2) begin
         s_nxt.wrPtr = s_r.wrPtr + 13'h0001;
         s_nxt.storedP = 1'b1;
      end
      wrCnt = s_nxt.wrPtr - s_r.rdCopy[SK-1];
      // A stale flag is expected: only the owning clock may refresh it
      if (wrEdge) begin
         s_nxt.fullW = wrCnt >= depth;
         s_nxt.afW = (depth - wrCnt) <= thr;
         s_nxt.hfW = wrCnt > (depth >> 1);
      end

      // Read side: a shown-empty edge is latent whatever the enable
      if (rdEdge && !s_r.emptyR && !s_r.renS2) begin
         s_nxt.rdPtr = s_r.rdPtr + 13'h0001;
         s_nxt.deliveredP = 1'b1;
      end
      rdCnt = s_r.wrCopy[SK-1] - s_nxt.rdPtr;
      if (rdEdge) begin
         s_nxt.emptyR = rdCnt == 13'h0000;
         s_nxt.aeR = rdCnt <= thr;
      end

      // Bus write channel: address and data taken in either order
      if (awvalid && awready) begin
         s_nxt.awHeld = 1'b1;
         s_nxt.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         s_nxt.wHeld = 1'b1;
         s_nxt.wData = wdata;
         s_nxt.wStrb = wstrb;
      end
      case (s_r.wrSt)
         dcf_pkg::WR_IDLE: begin
            if (s_nxt.awHeld && s_nxt.wHeld) begin
               s_nxt.awHeld = 1'b0;
               s_nxt.wHeld = 1'b0;
               s_nxt.wrSt = dcf_pkg::WR_RESP;
               s_nxt.bResp = dcf_pkg::RESP_OKAY;
               if ({s_nxt.awAddr[3:2], 2'h0} == dcf_pkg::ADDR_CTRL) begin
                  if (s_nxt.wStrb[0]) begin
                     s_nxt.code = s_nxt.wData[dcf_pkg::CTRL_CODE_LSB +: 6];
                     s_nxt.variant = s_nxt.wData[dcf_pkg::CTRL_VAR_LSB +: 2];
                  end
                  if (s_nxt.wStrb[1]) begin
                     s_nxt.cascade = s_nxt.wData[dcf_pkg::CTRL_CASC_BIT];
                  end
               end else begin
                  s_nxt.bResp = dcf_pkg::RESP_SLVERR;
               end
            end
         end
         dcf_pkg::WR_RESP: begin
            if (bready) begin
               s_nxt.wrSt = dcf_pkg::WR_IDLE;
            end
         end
         default: s_nxt.wrSt = dcf_pkg::WR_IDLE;
      endcase
      // A variant change can push an old code out of range
      s_nxt.code = limitCode(s_nxt.code, s_nxt.variant);

      // Outputs take the newest owner-side flags
      // Pins follow the next flags, so they move on the update edge itself
      s_nxt.efN = ~(s_nxt.emptyR | s_nxt.fullW);
      s_nxt.pafeN = s_nxt.cascade | ~(s_nxt.aeR | s_nxt.afW);
      s_nxt.hfN = ~s_nxt.hfW;

      // Bus read channel, one outstanding read
      // Status returns the flags as last registered, not a live recount
      if (s_r.rValid && rready) begin
         s_nxt.rValid = 1'b0;
      end
      if (arvalid && arready) begin
         s_nxt.rValid = 1'b1;
         s_nxt.rResp = dcf_pkg::RESP_OKAY;
         s_nxt.rData = 32'h0000_0000;
         case ({araddr[3:2], 2'h0})
            dcf_pkg::ADDR_CTRL: begin
               s_nxt.rData[dcf_pkg::CTRL_CODE_LSB +: 6] = s_r.code;
               s_nxt.rData[dcf_pkg::CTRL_VAR_LSB +: 2] = s_r.variant;
               s_nxt.rData[dcf_pkg::CTRL_CASC_BIT] = s_r.cascade;
            end
            dcf_pkg::ADDR_STATUS: begin
               s_nxt.rData[dcf_pkg::ST_EMPTY_BIT] = s_r.emptyR;
               s_nxt.rData[dcf_pkg::ST_AE_BIT] = s_r.aeR;
               s_nxt.rData[dcf_pkg::ST_HF_BIT] = s_r.hfW;
               s_nxt.rData[dcf_pkg::ST_AF_BIT] = s_r.afW;
               s_nxt.rData[dcf_pkg::ST_FULL_BIT] = s_r.fullW;
               s_nxt.rData[dcf_pkg::ST_EFN_BIT] = s_r.efN;
               s_nxt.rData[dcf_pkg::ST_PAFEN_BIT] = s_r.pafeN;
               s_nxt.rData[dcf_pkg::ST_HFN_BIT] = s_r.hfN;
               s_nxt.rData[dcf_pkg::ST_COUNT_LSB +: PW] = s_r.wrPtr - s_r.rdPtr;
            end
            dcf_pkg::ADDR_PTRS: begin
               s_nxt.rData[PW-1:0] = s_r.wrPtr;
               s_nxt.rData[dcf_pkg::PTRS_RD_LSB +: PW] = s_r.rdPtr;
            end
            default: s_nxt.rResp = dcf_pkg::RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
         s_r.wenS1 <= 1'b1;
         s_r.wenS2 <= 1'b1;
         s_r.renS1 <= 1'b1;
         s_r.renS2 <= 1'b1;
         s_r.emptyR <= 1'b1;
         s_r.aeR <= 1'b1;
         s_r.hfN <= 1'b1;
         s_r.code <= dcf_pkg::CODE_RST;
         s_r.variant <= dcf_pkg::VAR_RST;
         s_r.cascade <= dcf_pkg::CASC_RST;
         s_r.wrSt <= dcf_pkg::WR_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wordStored = s_r.storedP;
   assign wordDelivered = s_r.deliveredP;
   assign empty_full_flag_n = s_r.efN;
   assign near_boundary_flag_n = s_r.pafeN;
   assign half_level_flag_n = s_r.hfN;
   assign awready = (s_r.wrSt == dcf_pkg::WR_IDLE) && !s_r.awHeld;
   assign wready = (s_r.wrSt == dcf_pkg::WR_IDLE) && !s_r.wHeld;
   assign bvalid = s_r.wrSt == dcf_pkg::WR_RESP;
   assign bresp = s_r.bResp;
   assign arready = !s_r.rValid;
   assign rvalid = s_r.rValid;
   assign rdata = s_r.rData;
   assign rresp = s_r.rResp;

   // Checks run on core_clk; reset masks the values sampled while it is low
   default clocking dcf_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   empty_read_edge_a: assert property (
      (s_r.emptyR != $past(s_r.emptyR)) || (s_r.aeR != $past(s_r.aeR)) |-> $past(rdEdge))
      else $error("Empty-side flag moved without a read edge");
   full_write_edge_a: assert property (
      (s_r.fullW != $past(s_r.fullW)) || (s_r.hfW != $past(s_r.hfW)) |-> $past(wrEdge))
      else $error("Full-side flag moved without a write edge");
   last_word_a: assert property (
      rdEdge && !s_r.emptyR && !s_r.renS2 && (s_r.wrCopy[SK-1] - s_r.rdPtr == 13'h0001)
      |=> s_r.emptyR ##1 !empty_full_flag_n && (near_boundary_flag_n == s_r.cascade)
      && half_level_flag_n)
      else $error("Reading last word did not show empty");
   fill_full_a: assert property (
      wrEdge && !s_r.fullW && !s_r.wenS2 && (s_r.variant == dcf_pkg::VAR_2K)
      && (s_r.wrPtr - s_r.rdCopy[SK-1] == 13'h07ff)
      |=> s_r.fullW ##1 !empty_full_flag_n && (near_boundary_flag_n == s_r.cascade)
      && !half_level_flag_n)
      else $error("Word 2048 did not show full");
   code_limit_a: assert property (
      s_r.variant == dcf_pkg::VAR_512 |-> s_r.code <= dcf_pkg::CODE_MAX_512)
      else $error("Distance code out of range");
   zero_code_a: assert property (
      s_r.code == 6'h00 |-> (s_r.aeR == s_r.emptyR) && (s_r.afW == s_r.fullW))
      else $error("Zero code did not tie near flags to boundaries");
   latent_read_a: assert property (
      rdEdge && s_r.emptyR |=> $stable(s_r.rdPtr) && !wordDelivered)
      else $error("Latent read edge moved the count");
   latent_write_a: assert property (
      wrEdge && s_r.fullW |=> $stable(s_r.wrPtr) && !wordStored)
      else $error("Latent write edge stored a word");
   latent_clear_a: assert property (
      rdEdge && s_r.emptyR && (s_r.wrCopy[SK-1] != s_r.rdPtr) |=> !s_r.emptyR)
      else $error("Latent read edge left empty shown");
   full_clear_a: assert property (
      wrEdge && s_r.fullW && (s_r.wrPtr - s_r.rdCopy[SK-1] < depth) |=> !s_r.fullW)
      else $error("Latent write edge left full shown");
   cascade_off_a: assert property (
      s_r.cascade |-> near_boundary_flag_n)
      else $error("Near flag driven in cascade mode");
   write_moves_a: assert property (
      wrEdge && !s_r.fullW && !s_r.wenS2 |=> s_r.wrPtr == $past(s_r.wrPtr) + 13'h0001)
      else $error("Enabled write did not advance count");

   latent_read_c: cover property (rdEdge && s_r.emptyR && (s_r.wrCopy[SK-1] != s_r.rdPtr));
   full_reached_c: cover property (!s_r.fullW ##1 s_r.fullW);
   half_cross_c: cover property (s_r.hfW ##1 !s_r.hfW);
   cascade_set_c: cover property (!s_r.cascade ##1 s_r.cascade);
   full_latent_c: cover property (wrEdge && s_r.fullW && s_r.wenS2);
endmodule : dcf_flags
`default_nettype wire

// ==== testbench/dcf_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcf_host (
   // Pacing clock
   input wire logic core_clk,
   // Write side pins
   output logic write_clock,
   output logic write_enable_n,
   // Read side pins
   output logic read_clock,
   output logic read_enable_n
);
   initial begin
      write_clock <= 1'h0;
      read_clock <= 1'h0;
      write_enable_n <= 1'h1;
      read_enable_n <= 1'h1;
   end

   // One 200 ns frame (8 core_clk) per op; the clocks stand still between frames.
   // Ops lie a full frame apart, well beyond the include skew.
   task automatic op(input bit isWr, input bit en);
      if (isWr) begin
         write_enable_n <= !en;
         @(posedge core_clk);
         write_clock <= 1'h1;
         repeat (4) @(posedge core_clk);
         write_clock <= 1'h0;
         repeat (2) @(posedge core_clk);
         write_enable_n <= 1'h1;
      end else begin
         read_enable_n <= !en;
         @(posedge core_clk);
         read_clock <= 1'h1;
         repeat (4) @(posedge core_clk);
         read_clock <= 1'h0;
         repeat (2) @(posedge core_clk);
         read_enable_n <= 1'h1;
      end
      @(posedge core_clk);
   endtask : op
endmodule : dcf_host
`default_nettype wire

// ==== testbench/dcf_flags_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcf_flags_bench;
   logic core_clk = 1'h0;
   logic rst_b = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp, rsp;
   logic awready, wready, bvalid, arready, rvalid, wordStored, wordDelivered;
   logic wrClk, wrEn_n, rdClk, rdEn_n, efN, nbN, hlN;
   logic [2:0] pins;
   int n_mismatch = 0, comparisons = 0, nStored = 0, nDeliv = 0, cyc = 0;

   assign pins = {efN, nbN, hlN};
   always #12.5 core_clk = ~core_clk;

   dcf_host i_dcf_host (.core_clk(core_clk), .write_clock(wrClk), .write_enable_n(wrEn_n),
      .read_clock(rdClk), .read_enable_n(rdEn_n));

   dcf_flags i_dcf_flags (.core_clk(core_clk), .rst_b(rst_b), .write_clock(wrClk),
      .write_enable_n(wrEn_n), .wordStored(wordStored), .read_clock(rdClk),
      .read_enable_n(rdEn_n), .wordDelivered(wordDelivered), .empty_full_flag_n(efN),
      .near_boundary_flag_n(nbN), .half_level_flag_n(hlN), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp));

   // Pulses are one cycle wide, so they are counted at every edge
   always @(posedge core_clk) begin
      cyc++;
      if (wordStored === 1'h1) nStored++;
      if (wordDelivered === 1'h1) nDeliv++;
      if (cyc == 40000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wrr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge core_clk);
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      bready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'h0;
   endtask : wrr

   task automatic rdr(input logic [3:0] a);
      @(posedge core_clk);
      arvalid <= 1'h1;
      araddr <= a;
      rready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rd = rdata;
      rsp = rresp;
      rready <= 1'h0;
   endtask : rdr

   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'h1;
      repeat (4) @(posedge core_clk);
      chk("reset flags", 32'h1, pins);
      rdr(dcf_pkg::ADDR_CTRL);
      chk("ctrl reset", 32'h81, rd);
      rdr(4'hc);
      chk("unmapped resp", dcf_pkg::RESP_SLVERR, rsp);
      wrr(dcf_pkg::ADDR_STATUS, 32'h0, 4'hf);
      chk("read-only resp", dcf_pkg::RESP_SLVERR, rsp);
      wrr(dcf_pkg::ADDR_CTRL, 32'h3f, 4'h1);
      rdr(dcf_pkg::ADDR_CTRL);
      chk("code clamp", 32'h0f, rd);
      wrr(dcf_pkg::ADDR_CTRL, 32'h41, 4'h3);
      $display("test registers done");
      i_dcf_host.op(1'h1, 1'h1);
      chk("empty held", 32'h1, pins);
      i_dcf_host.op(1'h0, 1'h0);
      chk("latent read", 32'h5, pins);
      chk("latent no data", 32'h0, nDeliv);
      i_dcf_host.op(1'h0, 1'h1);
      chk("last word", 32'h1, pins);
      chk("delivered", 32'h1, nDeliv);
      $display("test empty boundary done");
      for (int n = 1; n <= 2048; n++) begin
         i_dcf_host.op(1'h1, 1'h1);
         // Read side is refreshed once, so the pins reflect only write-side states
         if (n == 1024) i_dcf_host.op(1'h0, 1'h0);
         case (n)
            1024: chk("half", 32'h7, pins);
            1025: chk("over half", 32'h6, pins);
            2031: chk("below near full", 32'h6, pins);
            2032: chk("near full", 32'h4, pins);
            2048: chk("full", 32'h0, pins);
            default: ;
         endcase
      end
      chk("stored", 32'h801, nStored);
      $display("test fill done");
      i_dcf_host.op(1'h1, 1'h1);
      chk("refused", 32'h801, nStored);
      i_dcf_host.op(1'h0, 1'h1);
      chk("full held", 32'h0, pins);
      i_dcf_host.op(1'h1, 1'h0);
      chk("latent write", 32'h4, pins);
      chk("latent no store", 32'h801, nStored);
      rdr(dcf_pkg::ADDR_STATUS);
      chk("count", 32'h7ff, {19'h0, rd[28:16]});
      chk("status bits", 32'h2c, {24'h0, rd[7:0]});
      rdr(dcf_pkg::ADDR_PTRS);
      chk("pointers", 32'h0002_0801, rd);
      i_dcf_host.op(1'h1, 1'h1);
      chk("full again", 32'h0, pins);
      $display("test full boundary done");
      wrr(dcf_pkg::ADDR_CTRL, 32'h40, 4'h1);
      i_dcf_host.op(1'h0, 1'h1);
      i_dcf_host.op(1'h1, 1'h0);
      chk("code zero", 32'h6, pins);
      wrr(dcf_pkg::ADDR_CTRL, 32'h141, 4'h3);
      i_dcf_host.op(1'h1, 1'h0);
      chk("cascade", 32'h6, pins);
      $display("test code and cascade done");
      give_verdict();
   end
endmodule : dcf_flags_bench
`default_nettype wire
